// [logic/byte_fifo.sv]
// word fifo with registered read data
`default_nettype none
module byte_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 32
) (
   input  wire logic clk,
   input  wire logic rst_n,
   stream_if.snk     fill,
   stream_if.src     drain,
   output var  logic empty
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
   end

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0]   cnt_q;
   logic          out_v_q;
   logic [W-1:0]  out_d_q;

   wire push = fill.valid && fill.ready;
   wire pop  = (cnt_q != '0) && (!out_v_q || drain.ready);

   assign fill.ready  = cnt_q != (AW+1)'(DEPTH);
   assign drain.valid = out_v_q;
   assign drain.data  = out_d_q;
   assign empty       = (cnt_q == '0) && !out_v_q;

   always_ff @(posedge clk) begin
      if (push)
         mem_q[wp_q] <= fill.data;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q    <= '0;
         rp_q    <= '0;
         cnt_q   <= '0;
         out_v_q <= 1'b0;
         out_d_q <= '0;
      end else begin
         wp_q  <= push ? wp_q + AW'(1) : wp_q;
         rp_q  <= pop ? rp_q + AW'(1) : rp_q;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
         if (pop) begin
            out_v_q <= 1'b1;
            out_d_q <= mem_q[rp_q];
         end else if (drain.ready)
            out_v_q <= 1'b0;
      end
   end

   a_fifo_no_overfill : assert property (@(posedge clk) disable iff (!rst_n)
      cnt_q == (AW+1)'(DEPTH) |=> cnt_q <= (AW+1)'(DEPTH))
      else $error("fifo count past depth");
endmodule : byte_fifo
`default_nettype wire

// [logic/flash_pkg.sv]
// shared opcodes, address fields, timing and state types for the sequencer
`default_nettype none
package flash_pkg;
   localparam logic [7:0] OP_SECPROG = 8'h42;
   localparam logic [7:0] OP_PP      = 8'h02;
   localparam logic [7:0] OP_PP_ALT  = 8'hF2;
   localparam logic [7:0] OP_QPP     = 8'h32;
   localparam logic [7:0] OP_SE      = 8'h20;
   localparam logic [7:0] OP_RSTEN   = 8'h66;
   localparam logic [7:0] OP_RST     = 8'h99;
   localparam logic [7:0] OP_WREN    = 8'h06;

   localparam int          ADDR_W     = 24;
   localparam int          BYTE_W     = 8;
   localparam int          BUF_W      = ADDR_W + BYTE_W;
   localparam int          SEC_HI_LSB = 16;
   localparam int          SEC_SEL_LSB = 12;
   localparam int          SEC_MID_LSB = 8;
   localparam int          BLK_LSB    = 16;
   localparam int          BP_DIR_BIT = 4;
   localparam logic [2:0]  HDR_BYTES  = 3'h4;
   localparam logic [2:0]  DATA_SEEN  = 3'h5;
   localparam logic [2:0]  CMD_SEEN   = 3'h1;
   localparam logic [2:0]  BP_ALL     = 3'h7;
   localparam logic [2:0]  STEP_ONE   = 3'h1;
   localparam logic [2:0]  STEP_QUAD  = 3'h4;
   localparam logic [1:0]  SEC_FIRST  = 2'h1;
   localparam logic [1:0]  SEC_LAST   = 2'h3;

   localparam logic [31:0] CLK_PERIOD_NS = 32'h0000_0032;
   localparam logic [31:0] RST_TIME_NS   = 32'h0000_7530;
   localparam logic [31:0] RST_CYC =
      (RST_TIME_NS + CLK_PERIOD_NS - 32'h1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      KIND_PROG  = 2'h0,
      KIND_SEC   = 2'h1,
      KIND_ERASE = 2'h2
   } kind_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_DRAIN = 2'h1,
      ST_BUSY  = 2'h2,
      ST_RST   = 2'h3
   } state_e;

   function automatic logic is_prog(input logic [7:0] cmd);
      is_prog = (cmd == OP_PP) || (cmd == OP_PP_ALT) ||
                (cmd == OP_QPP) || (cmd == OP_SECPROG);
   endfunction : is_prog

   // level n of 1 to 6 protects 2**(n-1) 64 kbyte blocks at top, or bottom if dir set; level 7 protects all
   function automatic logic is_protected(input logic [ADDR_W-1:0] addr,
                                         input logic [4:0]        bp);
      logic [2:0] lvl;
      logic [8:0] n;
      logic [8:0] blk;
      lvl = bp[2:0];
      blk = {1'b0, addr[BLK_LSB +: 8]};
      n   = 9'h001 << (lvl - 3'h1);
      if (lvl == 3'h0)
         is_protected = 1'b0;
      else if (lvl == BP_ALL)
         is_protected = 1'b1;
      else if (bp[BP_DIR_BIT])
         is_protected = blk < n;
      else
         is_protected = blk >= (9'h100 - n);
   endfunction : is_protected
endpackage : flash_pkg
`default_nettype wire

// [logic/flash_seq.sv]
// serial flash program, erase and software reset sequencer
// Function
// R01: security program is 42h, three address bytes, 1 to 256 data bytes.
// R02: host must set write enable first; without it nothing executes.
// R03: security address: high byte 00h, nibble 1 to 3, next nibble 0.
// R04: select rise starts timed cycle; busy flag held; write enable cleared.
// R05: a set security lock bit makes programs to that register ignored.
// R06: reset needs 66h then 99h directly; anything else cancels enable.
// R07: accepted reset aborts work and clears volatile state and write enable.
// R08: reset takes about 30 us and accepts no command meanwhile.
// R09: host should check busy and suspend before resetting.
// R10: page program is 02h or F2h, address, data, select held low.
// R11: data past page end wraps to the page start.
// R12: over 256 bytes, only the last 256 are programmed.
// R13: under 256 bytes, other page bytes stay unchanged.
// R14: program runs only if select rises on a whole byte.
// R15: select rise after a valid program starts the program cycle.
// R16: no page program into a page under block protection.
// R17: quad program is 32h on four lines, only with quad enable.
// R18: sector erase is 20h plus address; runs the erase cycle.
// R19: erase runs only if select rises right after the address.
// R20: no sector erase into a protected sector.
// R21: bits are taken on the serial clock rising edge.
// R22: while busy, program, erase and reset commands are ignored.
`default_nettype none
module flash_seq
   import flash_pkg::*;
#(
   parameter int          FIFO_DEPTH    = 32,
   parameter logic [31:0] PROG_TIME_US  = 32'h0000_03E8,
   parameter logic [31:0] ERASE_TIME_US = 32'h0001_86A0
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RST_N,
   input  wire logic              CS_N,
   input  wire logic              SCK,
   input  wire logic [3:0]        IO_IN,
   input  wire logic              QUAD_EN,
   input  wire logic [4:0]        BP_BITS,
   input  wire logic [2:0]        LOCK_BITS,
   input  wire logic              BUF_READY,
   output var  logic              WRITE_IN_PROGRESS,
   output var  logic              WRITE_ENABLE_LATCH,
   output var  logic              RESET_BUSY,
   output var  logic              CLR_VOLATILE,
   output var  logic              OP_GO,
   output var  logic [1:0]        OP_KIND,
   output var  logic [ADDR_W-1:0] OP_ADDR,
   output var  logic              OP_CANCEL,
   output var  logic              OVERRUN,
   output var  logic              BUF_VALID,
   output var  logic [ADDR_W-1:0] BUF_ADDR,
   output var  logic [BYTE_W-1:0] BUF_DATA
);
   localparam logic [31:0] US_NS     = 32'h0000_03E8;
   localparam logic [31:0] PROG_CYC  = PROG_TIME_US * US_NS / CLK_PERIOD_NS;
   localparam logic [31:0] ERASE_CYC = ERASE_TIME_US * US_NS / CLK_PERIOD_NS;

   if (PROG_CYC == 32'h0 || ERASE_CYC == 32'h0) begin : g_bad_time
      $error("cycle times must be at least one clock");
   end

   // pins cross into CLK_SYS through two flops before any use
   logic       cs_s1_q, cs_s2_q, cs_s3_q;
   logic       sck_s1_q, sck_s2_q, sck_s3_q;
   logic [3:0] io_s1_q, io_s2_q;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         {cs_s1_q, cs_s2_q, cs_s3_q}    <= 3'h7;
         {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
         io_s1_q <= 4'h0;
         io_s2_q <= 4'h0;
      end else begin
         {cs_s1_q, cs_s2_q, cs_s3_q}    <= {CS_N, cs_s1_q, cs_s2_q};
         {sck_s1_q, sck_s2_q, sck_s3_q} <= {SCK, sck_s1_q, sck_s2_q};
         io_s1_q <= IO_IN;
         io_s2_q <= io_s1_q;
      end
   end

   state_e             st_q, st_d;
   logic [7:0]         sh_q, cmd_q, off_q;
   logic [2:0]         bit_q, byte_q;
   logic [ADDR_W-1:0]  addr_q;
   logic               pushed_q, rst_en_q;
   logic [31:0]        cnt_q;
   logic               empty;

   stream_if #(.W(BUF_W)) fill_s ();
   stream_if #(.W(BUF_W)) drain_s ();

   // shift and byte framing
   wire       sck_rise  = sck_s2_q && !sck_s3_q && !cs_s2_q;       // [R21]
   wire       cs_rise   = cs_s2_q && !cs_s3_q;
   wire       quad_ph   = (byte_q != 3'h0) && (cmd_q == OP_QPP);   // [R17]
   wire [2:0] bit_nxt   = bit_q + (quad_ph ? STEP_QUAD : STEP_ONE);
   wire [7:0] sh_nxt    = quad_ph ? {sh_q[3:0], io_s2_q}
                                  : {sh_q[6:0], io_s2_q[0]};
   wire       byte_done = sck_rise && (bit_nxt == 3'h0);
   wire       in_data   = byte_q >= HDR_BYTES;

   // admission checks, evaluated once the address is known
   wire [1:0] sec_sel = addr_q[SEC_SEL_LSB +: 2];
   wire       sec_ok  = (addr_q[SEC_HI_LSB +: 8] == 8'h00)            // [R03]
                     && (addr_q[SEC_SEL_LSB + 2 +: 2] == 2'h0)
                     && (sec_sel >= SEC_FIRST) && (sec_sel <= SEC_LAST)
                     && (addr_q[SEC_MID_LSB +: 4] == 4'h0)
                     && !LOCK_BITS[sec_sel - SEC_FIRST];               // [R05]
   wire       prot    = is_protected(addr_q, BP_BITS);                 // [R16]
   wire       area_ok = (cmd_q == OP_SECPROG) ? sec_ok : !prot;        // [R20]
   wire       gate_ok = (st_q == ST_IDLE) && WRITE_ENABLE_LATCH && area_ok            // [R02]
                     && ((cmd_q != OP_QPP) || QUAD_EN);                // [R17]
   wire       push_try = byte_done && in_data && is_prog(cmd_q) && gate_ok;

   assign fill_s.valid = push_try;
   // offset wraps in 8 bits, so later bytes overwrite earlier ones  [R11]
   assign fill_s.data  = {addr_q[ADDR_W-1:8], addr_q[7:0] + off_q, sh_nxt};
   assign drain_s.ready = BUF_READY;

   wire on_byte   = bit_q == 3'h0;                                     // [R14]
   wire prog_ok   = cs_rise && is_prog(cmd_q) && byte_q == DATA_SEEN
                 && on_byte && gate_ok;                                // [R15]
   wire erase_ok  = cs_rise && (cmd_q == OP_SE) && byte_q == HDR_BYTES
                 && on_byte && gate_ok;                                // [R19]
   wire cmd_only  = cs_rise && byte_q == CMD_SEEN && on_byte
                 && (st_q == ST_IDLE);                                 // [R22]
   wire rst_go    = cmd_only && (cmd_q == OP_RST) && rst_en_q;         // [R06]
   wire any_cmd   = cs_rise && (byte_q != 3'h0) && (st_q == ST_IDLE);
   wire drain_end = (st_q == ST_DRAIN) && empty;
   wire go        = drain_end || erase_ok;
   wire cyc_end   = cnt_q == 32'h1;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE: begin
            if (rst_go)
               st_d = ST_RST;
            else if (prog_ok)
               st_d = ST_DRAIN;
            else if (erase_ok)
               st_d = ST_BUSY;                                         // [R18]
         end
         ST_DRAIN: begin
            if (empty)
               st_d = ST_BUSY;
         end
         ST_BUSY: begin
            if (cyc_end)
               st_d = ST_IDLE;
         end
         ST_RST: begin
            if (cyc_end)
               st_d = ST_IDLE;                                         // [R08]
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sh_q   <= 8'h00;
         bit_q  <= 3'h0;
         byte_q <= 3'h0;
         cmd_q  <= 8'h00;
         addr_q <= '0;
         off_q  <= 8'h00;
      end else if (cs_s2_q) begin                                      // [R10]
         bit_q  <= 3'h0;
         byte_q <= 3'h0;
         off_q  <= 8'h00;
      end else if (sck_rise) begin
         sh_q  <= sh_nxt;
         bit_q <= bit_nxt;
         if (byte_done) begin
            byte_q <= (byte_q == DATA_SEEN) ? byte_q : byte_q + 3'h1;
            if (byte_q == 3'h0)
               cmd_q <= sh_nxt;                                        // [R01]
            else if (!in_data)
               addr_q <= {addr_q[ADDR_W-9:0], sh_nxt};
            else
               off_q <= off_q + 8'h01;                                 // [R12]
         end
      end
   end

   // a full buffer drops the byte; drain stalls the cycle start instead
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         pushed_q <= 1'b0;
         OVERRUN  <= 1'b0;
      end else begin
         pushed_q <= !cs_s2_q && (pushed_q || push_try);
         OVERRUN  <= (OVERRUN && !rst_go) || (push_try && !fill_s.ready);
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N)
         rst_en_q <= 1'b0;
      else if (any_cmd)
         rst_en_q <= cmd_only && (cmd_q == OP_RSTEN);                  // [R06]
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= ST_IDLE;
         cnt_q <= 32'h0;
      end else begin
         st_q <= st_d;
         if (rst_go)
            cnt_q <= RST_CYC;
         else if (drain_end)
            cnt_q <= PROG_CYC;
         else if (erase_ok)
            cnt_q <= ERASE_CYC;
         else if (cnt_q != 32'h0)
            cnt_q <= cnt_q - 32'h1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         WRITE_IN_PROGRESS          <= 1'b0;
         WRITE_ENABLE_LATCH          <= 1'b0;
         RESET_BUSY   <= 1'b0;
         CLR_VOLATILE <= 1'b0;
         OP_GO        <= 1'b0;
         OP_KIND      <= KIND_PROG;
         OP_ADDR      <= '0;
         OP_CANCEL    <= 1'b0;
      end else begin
         WRITE_IN_PROGRESS          <= (st_d == ST_DRAIN) || (st_d == ST_BUSY);      // [R04]
         RESET_BUSY   <= st_d == ST_RST;
         CLR_VOLATILE <= rst_go;                                       // [R07]
         OP_GO        <= go;
         OP_CANCEL    <= cs_rise && pushed_q && !prog_ok;              // [R13]
         if (rst_go || go)
            WRITE_ENABLE_LATCH <= 1'b0;                                               // [R04]
         else if (cmd_only && cmd_q == OP_WREN)
            WRITE_ENABLE_LATCH <= 1'b1;
         if (erase_ok) begin
            OP_KIND <= KIND_ERASE;
            OP_ADDR <= addr_q;
         end else if (prog_ok) begin
            OP_KIND <= (cmd_q == OP_SECPROG) ? KIND_SEC : KIND_PROG;
            OP_ADDR <= addr_q;
         end
      end
   end

   byte_fifo #(.W(BUF_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .fill  (fill_s),
      .drain (drain_s),
      .empty (empty)
   );

   assign BUF_VALID = drain_s.valid;
   assign BUF_ADDR  = drain_s.data[BUF_W-1:BYTE_W];
   assign BUF_DATA  = drain_s.data[BYTE_W-1:0];

   // helper: length of the reset busy window
   logic [31:0] rb_len_q;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N)
         rb_len_q <= 32'h0;
      else
         rb_len_q <= RESET_BUSY ? rb_len_q + 32'h1 : 32'h0;
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   a_go_clears_wel : assert property (OP_GO |-> !WRITE_ENABLE_LATCH && WRITE_IN_PROGRESS) // [R04]
      else $error("write enable not cleared at cycle start");
   a_wip_falls_clean : assert property ($fell(WRITE_IN_PROGRESS) |-> !WRITE_ENABLE_LATCH) // [R04]
      else $error("write enable left set after cycle");
   a_reset_length : assert property
      ($fell(RESET_BUSY) |-> rb_len_q == RST_CYC) // [R08]
      else $error("reset window has wrong length");
   a_reset_quiet : assert property
      (RESET_BUSY |-> !OP_GO && !WRITE_ENABLE_LATCH) // [R07]
      else $error("activity during reset window");
   a_reset_pair : assert property
      ($rose(CLR_VOLATILE) |-> $past(rst_en_q) ##0 RESET_BUSY[*2]) // [R06]
      else $error("reset taken without enable");
   a_lock_respected : assert property
      (OP_GO && OP_KIND == KIND_SEC |->
       !LOCK_BITS[OP_ADDR[SEC_SEL_LSB +: 2] - SEC_FIRST]) // [R05]
      else $error("locked security register programmed");
   a_erase_unprot : assert property // [R20]
      (OP_GO && OP_KIND == KIND_ERASE |-> !is_protected(OP_ADDR, BP_BITS))
      else $error("protected sector erased");
   a_quad_needs_qe : assert property
      (prog_ok && cmd_q == OP_QPP |-> QUAD_EN) // [R17]
      else $error("quad program without quad enable");
   a_busy_ignores : assert property
      (WRITE_IN_PROGRESS && cs_rise |=> st_q != ST_RST) // [R22]
      else $error("reset accepted while busy");
   a_erase_time : assert property
      (erase_ok |=> WRITE_IN_PROGRESS [*8]) // [R18]
      else $error("erase cycle ended early");

   c_prog : cover property (OP_GO && OP_KIND == KIND_PROG);
   c_sec : cover property (OP_GO && OP_KIND == KIND_SEC);
   c_erase : cover property (OP_GO && OP_KIND == KIND_ERASE);
   c_reset : cover property ($fell(RESET_BUSY));
endmodule : flash_seq
`default_nettype wire

// [logic/stream_if.sv]
// valid/ready word stream between the sequencer and its buffer
`default_nettype none
interface stream_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// [test/spi_host.sv]
// host controller model: drives select, serial clock and data pins
`default_nettype none
module spi_host (
   output var logic       cs_n,
   output var logic       sck,
   output var logic [3:0] io
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      io   = 4'h0;
   end
   // data set while the clock is low, taken on the rise
   task automatic bit_out(input logic [3:0] v);
      io = v;
      #200;
      sck = 1'b1;
      #200;
      sck = 1'b0;
   endtask : bit_out
   // bytes from index qf go on four lines, high nibble first
   // tail adds stray bits after the bytes; select rises off a byte boundary unless tail is a multiple of 8
   task automatic frame(input int qf, input int tail);
      cs_n = 1'b0;
      foreach (q[i]) begin
         if (i >= qf) begin
            bit_out(q[i][7:4]);
            bit_out(q[i][3:0]);
         end else begin
            for (int b = 7; b >= 0; b--) bit_out({~io[3:1], q[i][b]});
         end
      end
      repeat (tail) bit_out({~io[3:1], 1'b1});
      #200;
      cs_n = 1'b1;
      // clock parks low; released lines must not keep the last value
      io = ~io;
   endtask : frame
endmodule : spi_host
`default_nettype wire

// [test/tb_top.sv]
// top-level bench: reset, command frames, stream sink and verdict
`default_nettype none
module tb_top import flash_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk;
   logic              rst_n;
   logic              cs_n;
   logic              sck;
   logic [3:0]        io;
   logic              quad_en;
   logic [4:0]        bp;
   logic [2:0]        lock;
   logic              buf_ready;
   logic              write_in_progress;
   logic              write_enable_latch;
   logic              rst_busy;
   logic              clr_vol;
   logic              op_go;
   logic [1:0]        op_kind;
   logic [ADDR_W-1:0] op_addr;
   logic              cancel;
   logic              overrun;
   logic              buf_valid;
   logic [ADDR_W-1:0] buf_addr;
   logic [BYTE_W-1:0] buf_data;
   logic [31:0]       expq[$];
   logic              skip = 1'b0;
   int                errors = 0;
   int                checks = 0;
   int                gos = 0;
   int                cancels = 0;
   int                clrs = 0;
   int                busy_n = 0;
   int                c0;

   // program and erase cycles shortened to 20 clocks each
   flash_seq #(.PROG_TIME_US(32'h1), .ERASE_TIME_US(32'h1)) flash_seq_i (
      .CLK_SYS(clk), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck), .IO_IN(io),
      .QUAD_EN(quad_en), .BP_BITS(bp), .LOCK_BITS(lock),
      .BUF_READY(buf_ready), .WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch), .RESET_BUSY(rst_busy),
      .CLR_VOLATILE(clr_vol), .OP_GO(op_go), .OP_KIND(op_kind),
      .OP_ADDR(op_addr), .OP_CANCEL(cancel), .OVERRUN(overrun),
      .BUF_VALID(buf_valid), .BUF_ADDR(buf_addr), .BUF_DATA(buf_data));
   spi_host spi_host_i (.cs_n(cs_n), .sck(sck), .io(io));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      if (op_go === 1'b1) gos++;
      if (cancel === 1'b1) cancels++;
      if (clr_vol === 1'b1) clrs++;
      if (rst_busy === 1'b1) busy_n++;
      if (buf_valid === 1'b1 && buf_ready === 1'b1 && !skip)
         chk({buf_addr, buf_data}, expq.pop_front());
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   task automatic load(input logic [7:0] op, input logic [23:0] a,
                       input int n);
      logic [7:0] d;
      spi_host_i.q = '{op, a[23:16], a[15:8], a[7:0]};
      for (int i = 0; i < n; i++) begin
         d = 8'(i) ^ 8'hA5;
         spi_host_i.q.push_back(d);
         expq.push_back({a[23:8], 8'(a[7:0] + 8'(i)), d});
      end
   endtask : load

   task automatic one(input logic [7:0] op);
      spi_host_i.q = '{op};
      spi_host_i.frame(999, 0);
      repeat (10) @(negedge clk);
   endtask : one

   // waits for the start pulse, then times the busy flag
   task automatic go_check(input logic [1:0] kind, input logic [23:0] a);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (op_go !== 1'b1 && n < 400);
      if (n >= 400) begin
         errors++;
         results();
      end
      chk(write_in_progress, 1'b1);
      chk(op_kind, kind);
      chk(op_addr, a);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (write_in_progress === 1'b1 && n < 400);
      chk(n, 20);
      chk(write_enable_latch, 1'b0);
   endtask : go_check

   task automatic ok(input logic [7:0] op, input logic [23:0] a,
                     input int n, input logic [1:0] kind);
      one(OP_WREN);
      chk(write_enable_latch, 1'b1);
      load(op, a, n);
      spi_host_i.frame((op == OP_QPP) ? 1 : 999, 0);
      go_check(kind, a);
      chk(expq.size(), 0);
      repeat (10) @(negedge clk);
   endtask : ok

   // ce below zero: cancel pulse and streamed bytes are not judged
   task automatic try(input logic [7:0] op, input logic [23:0] a,
                      input int n, input int tail, input int ce);
      int g;
      int c;
      one(OP_WREN);
      skip = (ce < 0);
      load(op, a, n);
      g = gos;
      c = cancels;
      spi_host_i.frame((op == OP_QPP) ? 1 : 999, tail);
      repeat (80) @(negedge clk);
      chk(gos - g, 0);
      if (ce >= 0) chk(cancels - c, ce);
      if (ce == 0) chk(expq.size(), n);
      if (ce <= 0) expq.delete();
      skip = 1'b0;
   endtask : try

   task automatic idle();
      int n;
      n = 0;
      while ((write_in_progress !== 1'b0 || rst_busy !== 1'b0) && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) begin
         errors++;
         results();
      end
   endtask : idle

   initial begin
      rst_n = 1'b0;
      quad_en = 1'b0;
      bp = 5'h00;
      lock = 3'h0;
      buf_ready = 1'b1;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      chk({write_in_progress, write_enable_latch, rst_busy}, 3'h0);
      load(OP_SE, 24'h012000, 0);
      spi_host_i.frame(999, 0);
      repeat (80) @(negedge clk);
      chk(gos, 0);
      ok(OP_SE, 24'h012000, 0, KIND_ERASE);
      try(OP_SE, 24'h012000, 0, 8, 0);
      try(OP_SE, 24'h012000, 0, 3, 0);
      ok(OP_PP, 24'h0000FE, 3, KIND_PROG);
      ok(OP_PP_ALT, 24'h010203, 1, KIND_PROG);
      ok(OP_PP, 24'h000300, 260, KIND_PROG);
      try(OP_PP, 24'h000400, 2, 3, 1);
      bp = 5'h01;
      try(OP_SE, 24'hFF0000, 0, 0, 0);
      try(OP_PP, 24'hFF0010, 1, 0, 0);
      ok(OP_SE, 24'h100000, 0, KIND_ERASE);
      bp = 5'h00;
      try(OP_QPP, 24'h000410, 2, 0, -1);
      quad_en = 1'b1;
      ok(OP_QPP, 24'h000410, 2, KIND_PROG);
      ok(OP_SECPROG, 24'h002010, 2, KIND_SEC);
      try(OP_SECPROG, 24'h004000, 1, 0, -1);
      try(OP_SECPROG, 24'h002100, 1, 0, -1);
      lock = 3'h2;
      try(OP_SECPROG, 24'h002000, 1, 0, -1);
      ok(OP_SECPROG, 24'h003000, 1, KIND_SEC);
      // stalled sink keeps the program busy; reset pair must be ignored
      one(OP_WREN);
      buf_ready = 1'b0;
      load(OP_PP, 24'h000500, 2);
      spi_host_i.frame(999, 0);
      repeat (10) @(negedge clk);
      chk(write_in_progress, 1'b1);
      c0 = clrs;
      one(OP_RSTEN);
      one(OP_RST);
      chk(clrs - c0, 0);
      chk(rst_busy, 1'b0);
      buf_ready = 1'b1;
      go_check(KIND_PROG, 24'h000500);
      // overflow the buffer with the sink stalled
      one(OP_WREN);
      buf_ready = 1'b0;
      skip = 1'b1;
      load(OP_PP, 24'h000600, 40);
      spi_host_i.frame(999, 0);
      repeat (10) @(negedge clk);
      chk(overrun, 1'b1);
      buf_ready = 1'b1;
      repeat (80) @(negedge clk);
      idle();
      expq.delete();
      skip = 1'b0;
      one(OP_RSTEN);
      one(OP_WREN);
      one(OP_RST);
      chk(clrs - c0, 0);
      chk(overrun, 1'b1);
      one(OP_RSTEN);
      busy_n = 0;
      one(OP_RST);
      chk(clrs - c0, 1);
      chk({write_enable_latch, overrun, rst_busy}, 3'h1);
      one(OP_WREN);
      chk(write_enable_latch, 1'b0);
      idle();
      chk(busy_n, 600);
      results();
   end
endmodule : tb_top
`default_nettype wire
